/* File: common/psv_pkg.sv */
// Package: register map, field positions, reset values and states of the power-save control block
package psv_pkg;
    // Register offsets (byte addresses, one aligned word each)
    localparam int unsigned ADDR_W       = 8;
    localparam logic [7:0]  OFF_PSC      = 8'h00;
    localparam logic [7:0]  OFF_PCC      = 8'h04;
    localparam logic [7:0]  OFF_CMD      = 8'h08;
    localparam logic [7:0]  OFF_STABILIZATION_TIME_SELECT_REG     = 8'h0C;
    localparam logic [7:0]  OFF_PCFG     = 8'h10;
    localparam logic [7:0]  OFF_IMSK     = 8'h14;
    localparam logic [7:0]  OFF_STAT     = 8'h18;
    // power_save_control_reg fields
    localparam int unsigned PSC_IDLE_BIT = 1;
    localparam int unsigned PSC_STOP_BIT = 2;
    // processor_clock_control_reg fields
    localparam int unsigned PCC_FRC_BIT  = 0;
    localparam int unsigned PCC_CKSEL_BIT = 1;
    // Peripheral sleep configuration fields
    localparam int unsigned CFG_TM0_WT   = 0;
    localparam int unsigned CFG_TM4_SUB  = 1;
    localparam int unsigned CFG_TM5_SUB  = 2;
    localparam int unsigned CFG_WT_SUB   = 3;
    localparam int unsigned CFG_CSI_LSB  = 4;
    localparam int unsigned CFG_UART_LSB = 8;
    localparam int unsigned CFG_INT7_SUB = 10;
    localparam int unsigned CFG_W        = 11;
    // Reset values
    localparam logic [1:0]  PCC_RST      = 2'h0;
    localparam logic [2:0]  STABILIZATION_TIME_SELECT_REG_RST     = 3'h4;
    localparam logic [10:0] PCFG_RST     = 11'h000;
    // Stabilisation wait is 2^(STAB_BASE+select) clock cycles; reset select gives 2^18
    localparam int unsigned STAB_BASE    = 14;
    localparam int unsigned STAB_CNT_W   = 22;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // Operating states, Gray coded along run -> stop -> wait and run -> idle -> run; wait -> run changes both bits
    typedef enum logic [1:0] {
        PSV_RUN  = 2'b00,
        PSV_STOP = 2'b01,
        PSV_WAIT = 2'b11,
        PSV_IDLE = 2'b10
    } psv_state_t;
endpackage

/* File: core/psv_ctrl.sv */
// Power-save control: light sleep, deep sleep, wake-up and oscillator stabilisation wait
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module psv_ctrl
    import psv_pkg::*;
#(
    parameter int unsigned NUM_INT    = 8,
    // Wait is 2^(STAB_SHIFT+select) cycles; smaller values only shorten simulation
    parameter int unsigned STAB_SHIFT = STAB_BASE
) (
    // Clock and reset; CLK is the always-on control clock, not the main oscillator
    input  wire logic                CLK,
    input  wire logic                RST_N,
    // Register port
    input  wire logic [ADDR_W-1:0]   ADDR,
    input  wire logic [31:0]         WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [31:0]         RDATA,
    // Asynchronous wake and status inputs
    input  wire logic                NMI_REQ,
    input  wire logic [NUM_INT-1:0]  INT_REQ,
    input  wire logic                SUBCLK_PRESENT,
    input  wire logic                BUS_HOLD_REQUEST_N,
    // Clock generator controls
    output logic                     MAIN_OSC_EN,
    output logic                     CPU_CLK_EN,
    output logic                     PERIPH_CLK_EN,
    output logic                     SUB_FEEDBACK_CUT,
    // Bus
    output logic                     BUS_HOLD_ACKNOWLEDGE_N,
    output logic                     EXT_BUS_EN,
    // Peripheral run enables
    output logic                     TIMER_FIRST_EN,
    output logic                     TIMER_FIFTH_EN,
    output logic                     TIMER_SIXTH_EN,
    output logic                     WATCH_TIMER_EN,
    output logic      [3:0]          CLOCKED_SERIAL_EN,
    output logic      [1:0]          ASYNC_SERIAL_TX_EN,
    output logic      [1:0]          ASYNC_SERIAL_RX_EN,
    output logic                     EXTERNAL_INTERRUPT_SEVEN_EN,
    output logic                     WAKE_EVENT
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [NUM_INT+2:0] sync_a;
    logic [NUM_INT+2:0] sync_b;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {NMI_REQ, INT_REQ, SUBCLK_PRESENT, ~BUS_HOLD_REQUEST_N};
            sync_b <= sync_a;
        end
    end

    logic               nmi_s;
    logic [NUM_INT-1:0] int_s;
    logic               sub_s;
    logic               hold_s;
    assign {nmi_s, int_s, sub_s, hold_s} = sync_b;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    psv_state_t                state;
    psv_state_t                next_state;
    logic [1:0]                processor_clock_control_reg;
    logic [1:0]                next_pcc;
    logic [2:0]                stabilization_time_select_reg;
    logic [2:0]                next_stabilization_time_select_reg;
    logic [CFG_W-1:0]          pcfg;
    logic [CFG_W-1:0]          next_pcfg;
    logic [NUM_INT-1:0]        imsk;
    logic [NUM_INT-1:0]        next_imsk;
    logic                      unlock;
    logic                      next_unlock;
    logic [STAB_CNT_W-1:0]     stab_cnt;
    logic [STAB_CNT_W-1:0]     next_stab_cnt;
    logic [31:0]               next_rdata;
    logic                      wake;
    logic                      psc_wr;

    // Stabilisation length for the current select value
    function automatic logic [STAB_CNT_W-1:0] stab_len(input logic [2:0] sel);
        logic [4:0] sh;
        sh = 5'(STAB_SHIFT) + {2'h0, sel};
        if (sh > 5'(STAB_CNT_W - 1)) begin
            sh = 5'(STAB_CNT_W - 1);
        end
        stab_len = STAB_CNT_W'(1) << sh;
    endfunction

    // sampled on the always-on clock, so no main clock is needed to see them
    assign wake   = nmi_s | (|(int_s & ~imsk));
    // control register write only right after a command-protect write
    assign psc_wr = WR && (ADDR == OFF_PSC) && unlock;

    always_comb begin
        next_state    = state;
        next_pcc      = processor_clock_control_reg;
        next_stabilization_time_select_reg     = stabilization_time_select_reg;
        next_pcfg     = pcfg;
        next_imsk     = imsk;
        next_stab_cnt = stab_cnt;
        next_unlock   = WR && (ADDR == OFF_CMD);
        next_rdata    = 32'h0000_0000;
        if (WR) begin
            unique case (ADDR)
                OFF_PCC:  next_pcc  = WDATA[1:0];
                OFF_STABILIZATION_TIME_SELECT_REG: next_stabilization_time_select_reg = WDATA[2:0];
                OFF_PCFG: next_pcfg = WDATA[CFG_W-1:0];
                OFF_IMSK: next_imsk = WDATA[NUM_INT-1:0];
                default:  ;
            endcase
        end
        if (RD) begin
            unique case (ADDR)
                OFF_PSC:  next_rdata = {29'h0, state == PSV_STOP, state == PSV_IDLE, 1'b0};
                OFF_PCC:  next_rdata = {30'h0, processor_clock_control_reg};
                OFF_STABILIZATION_TIME_SELECT_REG: next_rdata = {29'h0, stabilization_time_select_reg};
                OFF_PCFG: next_rdata = {{(32-CFG_W){1'b0}}, pcfg};
                OFF_IMSK: next_rdata = {{(32-NUM_INT){1'b0}}, imsk};
                OFF_STAT: next_rdata = {28'h0, sub_s, wake, state};
                default:  next_rdata = 32'h0000_0000;
            endcase
        end
        unique case (state)
            PSV_RUN: begin
                // stop request, refused while CPU runs on subclock
                if (psc_wr && WDATA[PSC_STOP_BIT] && !processor_clock_control_reg[PCC_CKSEL_BIT]) begin
                    next_state = PSV_STOP;
                end else if (psc_wr && WDATA[PSC_IDLE_BIT]) begin
                    next_state = PSV_IDLE;
                end
            end
            PSV_IDLE: begin
                // Oscillator kept running, so no wait is needed here
                if (wake) begin
                    next_state = PSV_RUN;
                end
            end
            PSV_STOP: begin
                // interrupt wake loads the selected interval
                if (wake) begin
                    next_state    = PSV_WAIT;
                    next_stab_cnt = stab_len(stabilization_time_select_reg);
                end
            end
            PSV_WAIT: begin
                // hold clocks off until the count runs out
                if (stab_cnt <= STAB_CNT_W'(1)) begin
                    next_state    = PSV_RUN;
                    next_stab_cnt = '0;
                end else begin
                    next_stab_cnt = stab_cnt - STAB_CNT_W'(1);
                end
            end
        endcase
    end

    // Reset wakes into the wait state, so reset exit also waits out the oscillator
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state    <= PSV_WAIT;
            processor_clock_control_reg      <= PCC_RST;
            stabilization_time_select_reg     <= STABILIZATION_TIME_SELECT_REG_RST;
            pcfg     <= PCFG_RST;
            imsk     <= '1;
            unlock   <= 1'b0;
            stab_cnt <= STAB_CNT_W'(1) << (STAB_SHIFT + STABILIZATION_TIME_SELECT_REG_RST);
            RDATA    <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            processor_clock_control_reg      <= next_pcc;
            stabilization_time_select_reg     <= next_stabilization_time_select_reg;
            pcfg     <= next_pcfg;
            imsk     <= next_imsk;
            unlock   <= next_unlock;
            stab_cnt <= next_stab_cnt;
            RDATA    <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enables, computed from the next state so they change with it; WAKE_EVENT is taken from the current state
    logic n_run;
    logic n_idle;
    logic n_stop;
    logic n_sub;

    always_comb begin
        n_run  = (next_state == PSV_RUN);
        n_idle = (next_state == PSV_IDLE);
        n_stop = (next_state == PSV_STOP);
        n_sub  = sub_s;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MAIN_OSC_EN                 <= 1'b1;
            CPU_CLK_EN                  <= 1'b0;
            PERIPH_CLK_EN               <= 1'b0;
            SUB_FEEDBACK_CUT            <= 1'b0;
            BUS_HOLD_ACKNOWLEDGE_N      <= 1'b1;
            EXT_BUS_EN                  <= 1'b0;
            TIMER_FIRST_EN              <= 1'b0;
            TIMER_FIFTH_EN              <= 1'b0;
            TIMER_SIXTH_EN              <= 1'b0;
            WATCH_TIMER_EN              <= 1'b0;
            CLOCKED_SERIAL_EN           <= 4'h0;
            ASYNC_SERIAL_TX_EN          <= 2'h0;
            ASYNC_SERIAL_RX_EN          <= 2'h0;
            EXTERNAL_INTERRUPT_SEVEN_EN <= 1'b0;
            WAKE_EVENT                  <= 1'b0;
        end else begin
            // main oscillator off only in deep sleep
            MAIN_OSC_EN                 <= !n_stop;
            // CPU clock gated; execution halts with state held
            CPU_CLK_EN                  <= n_run;
            PERIPH_CLK_EN               <= n_run;
            // feedback cut only in deep sleep with a subclock
            SUB_FEEDBACK_CUT            <= n_stop && n_sub && next_pcc[PCC_FRC_BIT];
            // hold request not granted outside run
            BUS_HOLD_ACKNOWLEDGE_N      <= !(n_run && hold_s);
            EXT_BUS_EN                  <= n_run;
            // first timer counts on the watch interrupt
            TIMER_FIRST_EN              <= n_run || (n_sub && pcfg[CFG_TM0_WT]);
            TIMER_FIFTH_EN              <= n_run || (n_sub && pcfg[CFG_TM4_SUB]);
            TIMER_SIXTH_EN              <= n_run || (n_sub && pcfg[CFG_TM5_SUB]);
            WATCH_TIMER_EN              <= n_run || (n_sub && (n_idle || pcfg[CFG_WT_SUB]));
            // clocked serial only with external serial clock
            CLOCKED_SERIAL_EN           <= n_run ? 4'hF : pcfg[CFG_CSI_LSB +: 4];
            ASYNC_SERIAL_TX_EN          <= n_run ? 2'h3 : pcfg[CFG_UART_LSB +: 2];
            ASYNC_SERIAL_RX_EN          <= n_run ? 2'h3 : 2'h0;
            EXTERNAL_INTERRUPT_SEVEN_EN <= n_run || (n_sub && pcfg[CFG_INT7_SUB]);
            WAKE_EVENT                  <= (state == PSV_STOP || state == PSV_IDLE) && wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_osc_off_in_stop;
        @(posedge CLK) disable iff (!RST_N) (state == PSV_STOP) |-> !MAIN_OSC_EN;
    endproperty
    a_osc_off_in_stop: assert property (p_osc_off_in_stop) else $error("main osc running in deep sleep");

    property p_cpu_gated;
        @(posedge CLK) disable iff (!RST_N) (state != PSV_RUN) |-> !CPU_CLK_EN && !PERIPH_CLK_EN;
    endproperty
    a_cpu_gated: assert property (p_cpu_gated) else $error("cpu clock on while asleep");

    property p_frc;
        @(posedge CLK) disable iff (!RST_N) SUB_FEEDBACK_CUT |-> state == PSV_STOP && processor_clock_control_reg[PCC_FRC_BIT];
    endproperty
    a_frc: assert property (p_frc) else $error("feedback cut outside deep sleep");

    property p_no_hold;
        @(posedge CLK) disable iff (!RST_N) (state != PSV_RUN) |-> BUS_HOLD_ACKNOWLEDGE_N;
    endproperty
    a_no_hold: assert property (p_no_hold) else $error("hold granted while asleep");

    property p_stop_entry;
        @(posedge CLK) disable iff (!RST_N)
            (state == PSV_RUN && psc_wr && WDATA[PSC_STOP_BIT] && !processor_clock_control_reg[PCC_CKSEL_BIT]) |=> state == PSV_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop request not taken");

    property p_stop_wake;
        @(posedge CLK) disable iff (!RST_N) (state == PSV_STOP && wake) |=> state == PSV_WAIT;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("deep sleep not released");

    property p_wait_len;
        @(posedge CLK) disable iff (!RST_N)
            (state == PSV_STOP && wake && stabilization_time_select_reg == 3'h0) |=> (state == PSV_WAIT)[*8] ##1 !CPU_CLK_EN;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("stabilisation wait cut short");

    property p_wait_done;
        @(posedge CLK) disable iff (!RST_N) (state == PSV_WAIT && stab_cnt == STAB_CNT_W'(1)) |=> state == PSV_RUN;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("wait did not end");

    property p_idle_entry;
        @(posedge CLK) disable iff (!RST_N)
            (state == PSV_RUN && psc_wr && WDATA[PSC_IDLE_BIT] && !WDATA[PSC_STOP_BIT]) |=> state == PSV_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle request not taken");

    property p_uart_rx;
        @(posedge CLK) disable iff (!RST_N) (state == PSV_STOP) |-> ASYNC_SERIAL_RX_EN == 2'h0;
    endproperty
    a_uart_rx: assert property (p_uart_rx) else $error("uart receive on in deep sleep");

    c_stop: cover property (@(posedge CLK) disable iff (!RST_N) state == PSV_STOP ##[1:20] state == PSV_WAIT);
    c_idle: cover property (@(posedge CLK) disable iff (!RST_N) state == PSV_IDLE ##[1:20] state == PSV_RUN);
    c_refused: cover property (@(posedge CLK) disable iff (!RST_N) WR && ADDR == OFF_PSC && !unlock);

endmodule // psv_ctrl

`default_nettype wire

/* File: verif/psv_wake_src.sv */
// Partner model: wake sources and bus hold requester facing the power-save block
`timescale 1ns/1ps
`default_nettype none

module psv_wake_src (
    // Clock and bench commands
    input  wire logic       CLK,
    input  wire logic       SLOW,
    input  wire logic       NMI_CMD,
    input  wire logic [7:0] INT_CMD,
    input  wire logic       HOLD_CMD,
    // Lines into the block
    output logic            NMI_REQ,
    output logic [7:0]      INT_REQ,
    output logic            BUS_HOLD_REQUEST_N
);
    logic [9:0] dly [0:4];

    // Slow mode lags every request by five cycles
    always_ff @(posedge CLK) begin
        dly[0] <= {HOLD_CMD, NMI_CMD, INT_CMD};
        for (int i = 1; i < 5; i++) begin
            dly[i] <= dly[i-1];
        end
    end

    assign NMI_REQ = SLOW ? dly[4][8] : NMI_CMD;
    assign INT_REQ = SLOW ? dly[4][7:0] : INT_CMD;
    // Request line is driven inverted, so release reads high
    assign BUS_HOLD_REQUEST_N = SLOW ? ~dly[4][9] : ~HOLD_CMD;
endmodule // psv_wake_src

`default_nettype wire

/* File: verif/psv_ctrl_bench.sv */
// Testbench: scenarios for power-save control
`timescale 1ns/1ps
`default_nettype none

module psv_ctrl_bench;
    import psv_pkg::*;

    // Short stabilisation base keeps the run brief; the count law is the design's
    localparam int unsigned STAB_SH   = 6;
    localparam int unsigned RST_WAIT  = 1 << (STAB_SH + STABILIZATION_TIME_SELECT_REG_RST);
    localparam int unsigned STOP_WAIT = 1 << STAB_SH;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        sub = 1'b1;
    logic        slow = 1'b0;
    logic        nmi_cmd = 1'b0;
    logic [7:0]  int_cmd = 8'h00;
    logic        hold_cmd = 1'b0;
    logic [31:0] rdata;
    logic [7:0]  irq;
    logic        nmi, hold_n, osc, cpu, per, fbc, ack_n, ext;
    logic        tm0, tm4, tm5, wt, int7;
    logic [3:0]  csi;
    logic [1:0]  tx, rx;
    logic        wake_ev;
    int          fails = 0;
    int          tests_run = 0;

    always #2.5 clk = ~clk;

    psv_wake_src u_psv_wake_src (.CLK(clk), .SLOW(slow), .NMI_CMD(nmi_cmd), .INT_CMD(int_cmd),
        .HOLD_CMD(hold_cmd), .NMI_REQ(nmi), .INT_REQ(irq), .BUS_HOLD_REQUEST_N(hold_n));

    psv_ctrl #(.NUM_INT(8), .STAB_SHIFT(STAB_SH)) u_psv_ctrl (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr_en), .RD(rd_en), .RDATA(rdata), .NMI_REQ(nmi), .INT_REQ(irq), .SUBCLK_PRESENT(sub),
        .BUS_HOLD_REQUEST_N(hold_n), .MAIN_OSC_EN(osc), .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per),
        .SUB_FEEDBACK_CUT(fbc), .BUS_HOLD_ACKNOWLEDGE_N(ack_n), .EXT_BUS_EN(ext),
        .TIMER_FIRST_EN(tm0), .TIMER_FIFTH_EN(tm4), .TIMER_SIXTH_EN(tm5), .WATCH_TIMER_EN(wt),
        .CLOCKED_SERIAL_EN(csi), .ASYNC_SERIAL_TX_EN(tx), .ASYNC_SERIAL_RX_EN(rx),
        .EXTERNAL_INTERRUPT_SEVEN_EN(int7), .WAKE_EVENT(wake_ev));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        // Drive only just after a rising edge
        if (!clk) @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        if (!clk) @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    // Unlock and request with no gap; any other write between would relock
    task automatic req(input logic [31:0] d);
        if (!clk) @(posedge clk);
        wr_en <= 1'b1;
        addr <= OFF_CMD;
        wdata <= 32'h0000_00A5;
        @(posedge clk);
        addr <= OFF_PSC;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_cpu(input int lim, output int n);
        n = 0;
        // Falling edges, where the registered enables have settled
        while (cpu !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                chk("cpu clock wait", 32'h0, 32'h1);
                end_sim();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] v;
        int          n;
        repeat (3) @(posedge clk);
        chk("osc in reset", osc, 32'h1);
        chk("ack in reset", ack_n, 32'h1);
        rst_n <= 1'b1;
        rd(OFF_STABILIZATION_TIME_SELECT_REG, v);
        chk("stabilization_time_select_reg reset", v, 32'h4);
        rd(OFF_IMSK, v);
        chk("mask reset", v, 32'hFF);
        rd(OFF_STAT, v);
        chk("state after reset", v[1:0], 32'h3);
        rd(8'h3C, v);
        chk("unmapped read", v, 32'h0);
        wait_cpu(2 * RST_WAIT, n);
        // The four reads above used eight edges of the wait
        chk("reset wait", n + 7, RST_WAIT);
        $display("Test reset done");
    endtask

    task automatic t_unlock();
        wr(OFF_PSC, 32'h4);
        chk("psc locked", osc, 32'h1);
        wr(OFF_CMD, 32'h0);
        wr(OFF_PCFG, 32'h0);
        wr(OFF_PSC, 32'h4);
        chk("unlock cleared", osc, 32'h1);
        wr(OFF_STABILIZATION_TIME_SELECT_REG, 32'h0);
        $display("Test unlock done");
    endtask

    task automatic t_idle();
        logic [31:0] v;
        int          n;
        wr(OFF_IMSK, 32'hFD);
        wr(OFF_PCFG, 32'h401);
        req(32'h2);
        chk("idle clocks", {osc, cpu, per, ext}, 32'h8);
        chk("idle enables", {tm0, tm4, tm5, wt, int7, csi, tx, rx}, 32'h1300);
        rd(OFF_PSC, v);
        chk("idle flag", v, 32'h2);
        int_cmd <= 8'h01;
        repeat (10) @(posedge clk);
        chk("masked ignored", cpu, 32'h0);
        int_cmd <= 8'h02;
        wait_cpu(8, n);
        chk("idle wake latency", n <= 4, 32'h1);
        chk("wake pulse", wake_ev, 32'h1);
        @(posedge clk);
        int_cmd <= 8'h00;
        $display("Test idle done");
    endtask

    task automatic t_stop_sub();
        logic [31:0] v;
        int          n;
        hold_cmd <= 1'b1;
        wr(OFF_PCC, 32'h1);
        wr(OFF_PCFG, 32'h25E);
        chk("hold granted in run", ack_n, 32'h0);
        req(32'h4);
        chk("stop clocks", {osc, cpu, per, ext, fbc, ack_n}, 32'h03);
        chk("stop enables", {tm0, tm4, tm5, wt, int7, csi, tx, rx}, 32'hE58);
        rd(OFF_PSC, v);
        chk("stop flag", v, 32'h4);
        slow <= 1'b1;
        nmi_cmd <= 1'b1;
        repeat (20) @(posedge clk);
        chk("stabilising", {osc, cpu}, 32'h2);
        wait_cpu(2 * STOP_WAIT, n);
        chk("stop wake wait", (n >= STOP_WAIT - 20) && (n <= STOP_WAIT - 4), 32'h1);
        @(posedge clk);
        nmi_cmd <= 1'b0;
        slow <= 1'b0;
        repeat (12) @(posedge clk);
        chk("hold granted again", ack_n, 32'h0);
        hold_cmd <= 1'b0;
        $display("Test stop with subclock done");
    endtask

    task automatic t_stop_nosub();
        int n;
        sub <= 1'b0;
        wr(OFF_PCC, 32'h2);
        wr(OFF_PCFG, 32'h7FF);
        req(32'h4);
        chk("stop on subclock cpu", {osc, cpu}, 32'h3);
        wr(OFF_PCC, 32'h0);
        req(32'h4);
        chk("nosub enables", {tm0, tm4, tm5, wt, int7, csi, tx, rx}, 32'h0FC);
        @(posedge clk);
        int_cmd <= 8'h02;
        wait_cpu(2 * STOP_WAIT, n);
        chk("int wake wait", (n >= STOP_WAIT) && (n <= STOP_WAIT + 11), 32'h1);
        @(posedge clk);
        int_cmd <= 8'h00;
        $display("Test stop without subclock done");
    endtask

    task automatic t_reset_wake();
        sub <= 1'b1;
        repeat (4) @(posedge clk);
        req(32'h4);
        chk("asleep", osc, 32'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk("reset restarts osc", {osc, cpu}, 32'h2);
        $display("Test reset wake done");
    endtask

    initial begin
        t_reset();
        t_unlock();
        t_idle();
        t_stop_sub();
        t_stop_nosub();
        t_reset_wake();
        end_sim();
    end
endmodule // psv_ctrl_bench

`default_nettype wire
